// *** rtl/clock_divider.v ***
`timescale 1ns/1ps
// =====================================================
// divides a clock enable stream by ratio_m1_i + 1, any ratio from 1 to 128
module clock_divider (
  // clock and reset
  input  wire       clock_i,
  input  wire       rst_n_i,
  // source tick and ratio
  input  wire       tick_i,
  input  wire [6:0] ratio_m1_i,
  // divided tick
  output reg        tick_o
);
  reg [6:0] count;
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count  <= 7'h00;
      tick_o <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (tick_i) begin
        if (count >= ratio_m1_i) begin
          count  <= 7'h00;
          tick_o <= 1'b1;
        end else begin
          count <= count + 7'h01;
        end
      end
    end
  end
endmodule

// *** rtl/cpu_clock_map.vh ***
`ifndef CPU_CLOCK_MAP_VH
`define CPU_CLOCK_MAP_VH
// register byte offsets
`define OFF_CPU_MODE_CONTROL   4'h0
`define OFF_OSC_DIV_RATIO      4'h4
`define OFF_INSTR_CONTROL      4'h8
`define OFF_CLOCK_STATUS       4'hc
// mode register fields
`define BIT_OSC_MODE           5
`define BIT_XOSC_STOP          4
`define BIT_IOSC_STOP          3
`define BIT_MODE1              1
`define BIT_MODE0              0
`define DIV_HI                 7
`define DIV_LO                 6
// division ratio field codes (bits 7:6)
`define DIV_XIN_DOUBLE         2'h0
`define DIV_XIN_HIGH           2'h1
`define DIV_XIN_MIDDLE         2'h2
`define DIV_INTERNAL           2'h3
// internal oscillator ratio codes
`define IDIV_1                 2'h0
`define IDIV_2                 2'h1
`define IDIV_8                 2'h2
`define IDIV_128               2'h3
// reset values
`define CPU_MODE_RESET         8'hc8
`define IDIV_RESET             2'h2
// lock mask: bits 5, 1, 0
`define LOCK_MASK              8'h23
`endif

// *** rtl/cpu_clock_mode_control.v ***
`timescale 1ns/1ps
`include "cpu_clock_map.vh"
// Behaviour
// RULE1: bit set/clear instruction on bits 2-4, 6, 7 locks bits 5, 1, 0.
// RULE2: bits 7:6 divide, bit 4 external stop, bit 3 internal stop steer clocks.
// RULE3: peripheral count sources follow the mode register division selection.
// RULE4: external source selected gives watchdog the undivided external clock.
// RULE5: internal source selected feeds internal oscillator to all peripherals.
// RULE6: internal mode divides internal oscillator by 1, 2, 8 or 128.
// RULE7: internal division ratio changes only the CPU clock, not peripherals.
// RULE8: after reset CPU runs from internal oscillator divided by eight.
// RULE9: switching back to internal oscillator forces divide by eight.
// RULE10: software without external oscillator writes 1001_0x00 to mode register.
// RULE11: bits 5, 1, 0 accept one write after reset, later writes ignored.
// RULE12: starts on internal oscillator; bit 5 picks ceramic or RC mode.
// RULE13: software uses double speed only with ceramic oscillation.
// RULE14: source and ratio changes take effect on a clock boundary.
module cpu_clock_mode_control (
  // clock and reset
  input  wire        clock_i,
  input  wire        rst_n_i,
  // oscillator pins (asynchronous)
  input  wire        ext_osc_i,
  input  wire        int_osc_i,
  // oscillator enables and main oscillator output
  output reg         ext_osc_enable_o,
  output reg         int_osc_enable_o,
  output reg         main_osc_output_o,
  // clock ticks and mode bits out
  output reg         cpu_clock_tick_o,
  output reg         periph_clock_tick_o,
  output reg         watchdog_clock_tick_o,
  output reg  [1:0]  osc_mode_bits_o,
  // axi4-lite write address
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);
  // =====================================================
  // pin synchronisers and edge ticks
  reg [2:0] ext_sync;
  reg [2:0] int_sync;
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_sync <= 3'h0;
      int_sync <= 3'h0;
    end else begin
      ext_sync <= {ext_sync[1:0], ext_osc_i};
      int_sync <= {int_sync[1:0], int_osc_i};
    end
  end
  wire ext_tick = ext_sync[1] & ~ext_sync[2] & ext_osc_enable_o;
  wire int_tick = int_sync[1] & ~int_sync[2] & int_osc_enable_o;

  // =====================================================
  // registers
  reg  [7:0] mode;
  reg  [1:0] idiv;
  reg        locked;
  reg        aw_held;
  reg        w_held;
  reg  [3:0] aw_addr;
  reg [31:0] w_data;
  reg  [3:0] w_strb;
  wire       do_write = aw_held & w_held & ~s_axi_bvalid;
  wire       wr_byte0 = do_write & w_strb[0];
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  // instruction control: bit 7 marks a single-bit instruction, bits 2:0 the bit
  wire       bit_instr = w_data[7];
  wire [2:0] bit_pos   = w_data[2:0];
  wire       bit_value = w_data[3];
  wire       instr_lock = (bit_pos >= 3'h2 && bit_pos <= 3'h4) || bit_pos >= 3'h6;

  reg  [7:0] next_mode;
  reg        next_locked;
  reg  [7:0] wr_val;
  always @* begin
    next_mode   = mode;
    next_locked = locked;
    wr_val      = mode;
    if (wr_byte0 && aw_addr == `OFF_CPU_MODE_CONTROL) begin
      wr_val = w_data[7:0];
    end else if (wr_byte0 && aw_addr == `OFF_INSTR_CONTROL && bit_instr) begin
      wr_val = mode;
      wr_val[bit_pos] = bit_value;
      if (instr_lock)
        next_locked = 1'b1; // RULE1
    end
    if (wr_byte0 && (aw_addr == `OFF_CPU_MODE_CONTROL ||
        (aw_addr == `OFF_INSTR_CONTROL && bit_instr))) begin
      if (locked)
        next_mode = (mode & `LOCK_MASK) | (wr_val & ~`LOCK_MASK); // RULE11
      else
        next_mode = wr_val;
      if (aw_addr == `OFF_CPU_MODE_CONTROL ||
          ((`LOCK_MASK >> bit_pos) & 8'h01) != 8'h00)
        next_locked = 1'b1; // RULE11
    end
  end

  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 4'h0;
      w_data       <= 32'h0;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      mode         <= `CPU_MODE_RESET; // RULE8 RULE12
      idiv         <= `IDIV_RESET;     // RULE8
      locked       <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr == `OFF_CPU_MODE_CONTROL || aw_addr == `OFF_OSC_DIV_RATIO ||
                         aw_addr == `OFF_INSTR_CONTROL) ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      mode   <= next_mode;
      locked <= next_locked;
      if (mode[`DIV_HI:`DIV_LO] != `DIV_INTERNAL &&
          next_mode[`DIV_HI:`DIV_LO] == `DIV_INTERNAL)
        idiv <= `IDIV_8; // RULE9
      else if (wr_byte0 && aw_addr == `OFF_OSC_DIV_RATIO)
        idiv <= w_data[1:0];
    end
  end

  // =====================================================
  // read channel
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'h0;
      case (s_axi_araddr)
        `OFF_CPU_MODE_CONTROL: s_axi_rdata <= {24'h0, mode};
        `OFF_OSC_DIV_RATIO:    s_axi_rdata <= {30'h0, idiv};
        `OFF_INSTR_CONTROL:    s_axi_rdata <= 32'h0;
        `OFF_CLOCK_STATUS:     s_axi_rdata <= {29'h0, locked, ext_osc_enable_o,
                                               int_osc_enable_o};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // =====================================================
  // clock selection and division
  wire use_int = (mode[`DIV_HI:`DIV_LO] == `DIV_INTERNAL);
  reg  [6:0] cpu_ratio;
  reg  [6:0] per_ratio;
  always @* begin
    case (idiv)
      `IDIV_1: cpu_ratio = 7'h00; // RULE6
      `IDIV_2: cpu_ratio = 7'h01;
      `IDIV_8: cpu_ratio = 7'h07;
      default: cpu_ratio = 7'h7f;
    endcase
    if (!use_int) begin
      case (mode[`DIV_HI:`DIV_LO])
        `DIV_XIN_DOUBLE: cpu_ratio = 7'h00; // RULE13
        `DIV_XIN_HIGH:   cpu_ratio = 7'h01;
        default:         cpu_ratio = 7'h07;
      endcase
    end
    per_ratio = use_int ? 7'h00 : cpu_ratio; // RULE3 RULE7
  end

  wire src_tick = use_int ? int_tick : ext_tick; // RULE2 RULE5
  wire cpu_tick;
  wire per_tick;
  clock_divider u_cpu_div (
    .clock_i    (clock_i),
    .rst_n_i    (rst_n_i),
    .tick_i     (src_tick),
    .ratio_m1_i (cpu_ratio),
    .tick_o     (cpu_tick)
  );
  clock_divider u_per_div (
    .clock_i    (clock_i),
    .rst_n_i    (rst_n_i),
    .tick_i     (src_tick),
    .ratio_m1_i (per_ratio),
    .tick_o     (per_tick)
  );

  // outputs registered so a ratio change lands on a tick boundary
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cpu_clock_tick_o      <= 1'b0;
      periph_clock_tick_o   <= 1'b0;
      watchdog_clock_tick_o <= 1'b0;
      ext_osc_enable_o      <= 1'b0;
      int_osc_enable_o      <= 1'b1;
      main_osc_output_o     <= 1'b0;
      osc_mode_bits_o       <= 2'h0;
    end else begin
      cpu_clock_tick_o      <= cpu_tick;  // RULE14
      periph_clock_tick_o   <= per_tick;  // RULE3 RULE5
      watchdog_clock_tick_o <= use_int ? int_tick : ext_tick; // RULE4 RULE5
      ext_osc_enable_o      <= ~mode[`BIT_XOSC_STOP] | ~use_int; // RULE2
      int_osc_enable_o      <= ~mode[`BIT_IOSC_STOP] | use_int;  // RULE2
      main_osc_output_o     <= ext_osc_enable_o & ~ext_sync[2] & ~mode[`BIT_OSC_MODE];
      osc_mode_bits_o       <= {mode[`BIT_MODE1], mode[`BIT_MODE0]};
    end
  end
endmodule

// *** testbench/cpu_clock_mode_control_chk.sv ***
`timescale 1ns/1ps
// ========================================
// port checker
module cpu_clock_mode_control_chk (
  input wire        clock_i,
  input wire        rst_n_i,
  input wire        ext_osc_enable_o,
  input wire        int_osc_enable_o,
  input wire        cpu_clock_tick_o,
  input wire        watchdog_clock_tick_o,
  input wire [1:0]  osc_mode_bits_o,
  input wire        s_axi_awready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // set once the mode bits have moved
  reg moved;
  always @(posedge clock_i or negedge rst_n_i)
    if (!rst_n_i) moved <= 1'b0;
    else if (osc_mode_bits_o != $past(osc_mode_bits_o)) moved <= 1'b1;
  a_reset_state: assert property ($rose(rst_n_i) |-> int_osc_enable_o &&
    !ext_osc_enable_o && osc_mode_bits_o == 2'h0) else $error("bad state after reset");
  a_mode_lock: assert property (moved |-> $stable(osc_mode_bits_o))
    else $error("mode bits changed twice");
  a_cpu_pulse: assert property (cpu_clock_tick_o |=> !cpu_clock_tick_o)
    else $error("cpu tick too long");
  a_wdog_pulse: assert property (watchdog_clock_tick_o |=> !watchdog_clock_tick_o)
    else $error("watchdog tick too long");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken during response");
  a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule
bind cpu_clock_mode_control cpu_clock_mode_control_chk chk (.clock_i(clock_i),
  .rst_n_i(rst_n_i), .ext_osc_enable_o(ext_osc_enable_o),
  .int_osc_enable_o(int_osc_enable_o), .cpu_clock_tick_o(cpu_clock_tick_o),
  .watchdog_clock_tick_o(watchdog_clock_tick_o), .osc_mode_bits_o(osc_mode_bits_o),
  .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// *** testbench/cpu_clock_mode_control_test.sv ***
`timescale 1ns/1ps
// ========================================
// self-checking bench
module cpu_clock_mode_control_test;
  reg         clock_i, rst_n_i, ext_osc_i, int_osc_i, busy, ha, hb, hc;
  reg         awvalid, wvalid, bready, arvalid, rready;
  reg  [3:0]  awaddr, araddr, wstrb;
  reg  [31:0] wdata, rd, lf;
  reg  [2:0]  oc;
  reg  [1:0]  resp, r;
  wire [31:0] rdata;
  wire [1:0]  bresp, rresp, mbits;
  wire        awready, wready, bvalid, arready, rvalid, xen, ien, xo, ct, pt, wt;
  integer     bad_count, total_checks, n, i, nc, np, nw, nx;
  cpu_clock_mode_control uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .ext_osc_i(ext_osc_i),
    .int_osc_i(int_osc_i), .ext_osc_enable_o(xen), .int_osc_enable_o(ien),
    .main_osc_output_o(xo), .cpu_clock_tick_o(ct), .periph_clock_tick_o(pt),
    .watchdog_clock_tick_o(wt), .osc_mode_bits_o(mbits), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // ========================================
  // helpers
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function integer dv(input [1:0] c);
    dv = (c == 2'h0) ? 1 : (c == 2'h1) ? 2 : (c == 2'h2) ? 8 : 128;
  endfunction
  function [31:0] near(input integer got, input integer exp);
    near = (got >= exp - 1 && got <= exp + 1) ? exp : got;
  endfunction
  task results;
    begin
      $display("checks=%0d mismatches=%0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task check(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      busy = 1;
      for (n = 0; n < 64 && busy; n = n + 1) begin
        @(negedge clock_i);
        ha = wready;
        hb = bvalid;
        hc = awready;
        resp = bresp;
        @(posedge clock_i);
        if (hc) awvalid <= 1'b0;
        if (ha) wvalid <= 1'b0;
        if (hb) bready <= 1'b0;
        if (hb) busy = 0;
      end
      if (busy) bad_count = bad_count + 1;
      if (busy) results;
      @(posedge clock_i);
    end
  endtask
  task rdr(input [3:0] a);
    begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      busy = 1;
      for (n = 0; n < 64 && busy; n = n + 1) begin
        @(negedge clock_i);
        ha = arready;
        hb = rvalid;
        rd = rdata;
        resp = rresp;
        @(posedge clock_i);
        if (ha) arvalid <= 1'b0;
        if (hb) rready <= 1'b0;
        if (hb) busy = 0;
      end
      if (busy) bad_count = bad_count + 1;
      if (busy) results;
      @(posedge clock_i);
    end
  endtask
  task cnt;
    begin
      nc = 0;
      np = 0;
      nw = 0;
      nx = 0;
      repeat (2048) begin
        @(negedge clock_i);
        nc = nc + ct;
        np = np + pt;
        nw = nw + wt;
        nx = nx + xo;
      end
      @(posedge clock_i);
    end
  endtask
  task hard_reset;
    begin
      rst_n_i <= 1'b0;
      repeat (8) @(posedge clock_i);
      rst_n_i <= 1'b1;
      @(posedge clock_i);
    end
  endtask
  // ========================================
  // clock, oscillators and sequence
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    oc <= oc + 3'h1;
    int_osc_i <= oc[2];
    ext_osc_i <= oc[1];
  end
  initial begin
    {rst_n_i, ext_osc_i, int_osc_i, awvalid, wvalid, bready, arvalid, rready} = 8'h0;
    {awaddr, araddr, wdata, oc} = 43'h0;
    wstrb = 4'hf;
    lf = 32'h07b24334;
    bad_count = 0;
    total_checks = 0;
    hard_reset;
    rdr(4'h0); check(rd, 32'hc8);
    rdr(4'h4); check(rd, 32'h2);
    rdr(4'hc); check(rd, 32'h3);
    rdr(4'h2); check(resp, 2'h2);
    for (i = 0; i < 4; i = i + 1) begin
      wr(4'h4, i); cnt;
      check(near(nc, 256 / dv(i)), 256 / dv(i));
      check(near(np, 256), 256);
      check(near(nw, 256), 256);
      check(near(nx, 1024), 1024);
      check(resp, 2'h0);
      lf = lfsr(lf); wr(4'h4, lf); rdr(4'h4);
      check(rd, {30'h0, lf[1:0]});
    end
    wr(4'h8, 32'h8a); rdr(4'h0); check(rd, 32'hcc);
    wr(4'h8, 32'h82); rdr(4'h0); check(rd, 32'hc8);
    wr(4'h0, 32'hf7); rdr(4'h0); check(rd, 32'hd4);
    rdr(4'hc); check(rd, 32'h5);
    wr(4'hc, 32'h0); check(resp, 2'h2);
    hard_reset;
    lf = lfsr(lf);
    r = lf[1:0];
    wr(4'h4, 32'h0);
    wr(4'h0, {24'h0, 6'h20, r}); rdr(4'h0); check(rd, {24'h0, 6'h20, r});
    check(mbits, r);
    rdr(4'hc); check(rd, 32'h7);
    cnt; check(near(nc, 64), 64);
    check(near(np, 64), 64);
    check(near(nw, 512), 512);
    check(near(nx, 1024), 1024);
    wr(4'h0, {24'h0, 6'h28, ~r}); rdr(4'h0); check(rd, {24'h0, 6'h20, r});
    check(mbits, r);
    wr(4'h0, 32'h40); cnt; check(near(nc, 256), 256);
    check(near(np, 256), 256);
    wr(4'h0, 32'h00); cnt; check(near(nc, 512), 512);
    check(near(np, 512), 512);
    wr(4'h0, 32'hc0); rdr(4'h4); check(rd, 32'h2);
    cnt; check(near(nc, 32), 32);
    wr(4'h8, 32'h8c); rdr(4'hc); check(rd, 32'h5);
    cnt; check(nx, 0);
    hard_reset;
    wr(4'h0, 32'h94); rdr(4'h0); check(rd, 32'h94);
    check(mbits, 2'h0);
    results;
  end
endmodule
